/* acs_pkg.sv */
// Constants, types and register map of the conversion sequencer
package acs_pkg;
    localparam int unsigned RES_W = 10;
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned CH_W = 2;
    localparam int unsigned EVT_W = 2;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_STATE = 8'h0C;
    localparam logic [7:0] OFS_DATA0 = 8'h10;
    localparam logic [7:0] OFS_DATA1 = 8'h14;
    localparam logic [7:0] OFS_DATA2 = 8'h18;
    localparam logic [7:0] OFS_DATA3 = 8'h1C;

    // Field positions in status and mask, control word width and start bit position
    localparam int unsigned EVT_END = 0;
    localparam int unsigned EVT_CHAN = 1;
    localparam int unsigned CTRL_W = 5;
    localparam int unsigned CTRL_START_POS = 0;

    // Comparator settle cycles per trial bit, covers the 3-flop sync
    localparam logic [7:0] SAR_BIT_CYCLES = 8'h08;
    localparam logic [2:0] HSIZE_WORD = 3'b010;

    typedef enum logic {ST_IDLE, ST_CONV} acs_state_e;

    typedef struct packed {
        logic trig_en;
        logic [CH_W-1:0] chan;
        logic scan;
        logic start;
    } acs_ctrl_s;

    localparam acs_ctrl_s CTRL_RST = '0;
    localparam logic [EVT_W-1:0] EVT_RST = '0;

    // Drive toward the analogue core
    typedef struct packed {
        logic sample;
        logic [CH_W-1:0] chan;
        logic [RES_W-1:0] code;
    } acs_ana_s;
endpackage : acs_pkg

/* acs_sync3.sv */
// Three-flop input synchroniser with agreement filter
`timescale 1ns/1ps
module acs_sync3 #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Data
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] val;
    } acs_sync_s;

    acs_sync_s s_q;
    acs_sync_s s_d;

    always_comb begin
        s_d = s_q;
        s_d.ff1 = async_i;
        s_d.ff2 = s_q.ff1;
        s_d.ff3 = s_q.ff2;
        // A bit changes only once the second and third flops agree
        s_d.val = (~(s_q.ff2 ^ s_q.ff3) & s_q.ff3) | ((s_q.ff2 ^ s_q.ff3) & s_q.val);
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sync_o = s_q.val;
endmodule : acs_sync3

/* acs_sar.sv */
// Successive-approximation register, one result per start
`timescale 1ns/1ps
module acs_sar (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // Control
    input wire logic start_i,
    input wire logic abort_i,
    input wire logic cmp_i,
    // Results
    output logic busy_o,
    output logic done_o,
    output logic [acs_pkg::RES_W-1:0] code_o,
    output logic [acs_pkg::RES_W-1:0] result_o
);
    localparam logic [acs_pkg::RES_W-1:0] ONE = 10'h001;

    typedef struct packed {
        logic busy;
        logic done;
        logic [3:0] bitidx;
        logic [7:0] cnt;
        logic [acs_pkg::RES_W-1:0] code;
        logic [acs_pkg::RES_W-1:0] result;
    } acs_sar_s;

    acs_sar_s s_q;
    acs_sar_s s_d;
    logic [acs_pkg::RES_W-1:0] trial;

    always_comb begin
        s_d = s_q;
        trial = s_q.code;
        s_d.done = 1'b0;
        if (abort_i) begin
            s_d.busy = 1'b0;
        end else if (start_i && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.bitidx = 4'(acs_pkg::RES_W - 1);
            s_d.code = ONE << (acs_pkg::RES_W - 1);
            s_d.cnt = acs_pkg::SAR_BIT_CYCLES - 8'h01;
        end else if (s_q.busy) begin
            if (s_q.cnt != 8'h00) begin
                s_d.cnt = s_q.cnt - 8'h01;
            end else begin
                // Comparator low means input below the trial code
                if (!cmp_i) begin
                    trial[s_q.bitidx] = 1'b0;
                end
                if (s_q.bitidx == 4'h0) begin
                    s_d.busy = 1'b0;
                    s_d.done = 1'b1;
                    s_d.code = trial;
                    s_d.result = trial;
                end else begin
                    s_d.bitidx = s_q.bitidx - 4'h1;
                    s_d.code = trial | (ONE << (s_q.bitidx - 4'h1));
                    s_d.cnt = acs_pkg::SAR_BIT_CYCLES - 8'h01;
                end
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy_o = s_q.busy;
    assign done_o = s_q.done;
    assign code_o = s_q.code;
    assign result_o = s_q.result;
endmodule : acs_sar

/* acs_seq.sv */
// Conversion sequencer top: AHB-Lite registers, mode control, results
`timescale 1ns/1ps
module acs_seq (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // External trigger and comparator, both asynchronous
    input wire logic ext_trigger_i,
    input wire logic comparator_i,
    // Analogue core drive
    output acs_pkg::acs_ana_s ana_o,
    // Interrupt
    output logic conversion_end_interrupt_o
);
    typedef struct packed {
        acs_pkg::acs_state_e st;
        acs_pkg::acs_ctrl_s ctrl;
        logic [acs_pkg::CH_W-1:0] ch;
        logic [acs_pkg::EVT_W-1:0] status;
        logic [acs_pkg::EVT_W-1:0] mask;
        logic [acs_pkg::NUM_CH-1:0][acs_pkg::RES_W-1:0] data;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic rd_wait;
        logic [31:0] rdata;
        logic trig_prev;
        logic go;
    } acs_seq_s;

    acs_seq_s s_q;
    acs_seq_s s_d;

    logic trig_sync;
    logic cmp_sync;
    logic sar_busy;
    logic sar_done;
    logic sar_abort;
    logic [acs_pkg::RES_W-1:0] sar_code;
    logic [acs_pkg::RES_W-1:0] sar_result;
    logic [acs_pkg::EVT_W-1:0] evt;
    logic wr_en;
    logic wr_start;
    logic [acs_pkg::CH_W-1:0] last_ch;

    acs_sync3 #(
        .W(1)
    ) u_trig_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(ext_trigger_i),
        .sync_o(trig_sync)
    );

    acs_sync3 #(
        .W(1)
    ) u_cmp_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i(comparator_i),
        .sync_o(cmp_sync)
    );

    acs_sar u_sar (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .start_i(s_q.go),
        .abort_i(sar_abort),
        .cmp_i(cmp_sync),
        .busy_o(sar_busy),
        .done_o(sar_done),
        .code_o(sar_code),
        .result_o(sar_result)
    );

    // Clearing start mid-conversion abandons the trial in flight
    assign sar_abort = (s_q.st == acs_pkg::ST_CONV) && !s_q.ctrl.start;

    // In scan mode the channel field names the last channel of the group
    assign last_ch = s_q.ctrl.chan;

    always_comb begin
        s_d = s_q;
        s_d.go = 1'b0;
        evt = '0;
        wr_en = s_q.ap_valid && s_q.ap_write;
        wr_start = 1'b0;

        // Write data phase; mode, channel and start land together
        if (wr_en) begin
            unique case (s_q.ap_addr)
                acs_pkg::OFS_CTRL: begin
                    s_d.ctrl = acs_pkg::acs_ctrl_s'(hwdata_i[acs_pkg::CTRL_W-1:0]);
                    wr_start = hwdata_i[acs_pkg::CTRL_START_POS];
                end
                acs_pkg::OFS_STATUS: begin
                    s_d.status = s_q.status & ~hwdata_i[acs_pkg::EVT_W-1:0];
                end
                acs_pkg::OFS_MASK: begin
                    s_d.mask = hwdata_i[acs_pkg::EVT_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Sequencer works from last cycle's settings
        unique case (s_q.st)
            acs_pkg::ST_IDLE: begin
                if (s_q.ctrl.start) begin
                    s_d.st = acs_pkg::ST_CONV;
                    s_d.ch = s_q.ctrl.scan ? '0 : s_q.ctrl.chan;
                    s_d.go = 1'b1;
                end
            end
            acs_pkg::ST_CONV: begin
                if (!s_q.ctrl.start) begin
                    s_d.st = acs_pkg::ST_IDLE;
                end else if (sar_done) begin
                    s_d.data[s_q.ch] = sar_result;
                    evt[acs_pkg::EVT_CHAN] = 1'b1;
                    if (!s_q.ctrl.scan) begin
                        evt[acs_pkg::EVT_END] = 1'b1;
                        s_d.st = acs_pkg::ST_IDLE;
                        // A start written in this very cycle is kept
                        if (!wr_start) begin
                            s_d.ctrl.start = 1'b0;
                        end
                    end else if (s_q.ch == last_ch) begin
                        evt[acs_pkg::EVT_END] = 1'b1;
                        s_d.ch = '0;
                        s_d.go = 1'b1;
                    end else begin
                        s_d.ch = s_q.ch + 2'b01;
                        s_d.go = 1'b1;
                    end
                end
            end
        endcase

        // Trigger edge after the hardware clear so the new start wins
        s_d.trig_prev = trig_sync;
        if (s_q.ctrl.trig_en && trig_sync && !s_q.trig_prev) begin
            s_d.ctrl.start = 1'b1;
        end

        // Hardware set wins over a same-cycle write-one clear
        s_d.status = s_d.status | evt;

        // Address phase: writes take no wait, reads take one
        s_d.ap_valid = hsel_i && htrans_i[1] && hready_i;
        s_d.ap_write = hwrite_i && (hsize_i == acs_pkg::HSIZE_WORD);
        s_d.ap_addr = haddr_i[7:0];
        s_d.rd_wait = s_d.ap_valid && !hwrite_i;
        if (!s_d.ap_valid) begin
            s_d.ap_write = 1'b0;
        end

        // Read data captured in the wait cycle, after any earlier write
        if (s_q.rd_wait) begin
            unique case (s_q.ap_addr)
                acs_pkg::OFS_CTRL: begin
                    s_d.rdata = {27'h000_0000, s_q.ctrl};
                end
                acs_pkg::OFS_STATUS: begin
                    s_d.rdata = {30'h0000_0000, s_q.status};
                end
                acs_pkg::OFS_MASK: begin
                    s_d.rdata = {30'h0000_0000, s_q.mask};
                end
                acs_pkg::OFS_STATE: begin
                    s_d.rdata = {28'h000_0000, sar_busy, s_q.st == acs_pkg::ST_CONV, s_q.ch};
                end
                acs_pkg::OFS_DATA0: begin
                    s_d.rdata = {22'h00_0000, s_q.data[0]};
                end
                acs_pkg::OFS_DATA1: begin
                    s_d.rdata = {22'h00_0000, s_q.data[1]};
                end
                acs_pkg::OFS_DATA2: begin
                    s_d.rdata = {22'h00_0000, s_q.data[2]};
                end
                acs_pkg::OFS_DATA3: begin
                    s_d.rdata = {22'h00_0000, s_q.data[3]};
                end
                default: begin
                    s_d.rdata = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.ctrl <= acs_pkg::CTRL_RST;
            s_q.status <= acs_pkg::EVT_RST;
            s_q.mask <= acs_pkg::EVT_RST;
            s_q.st <= acs_pkg::ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata_o = s_q.rdata;
    assign hreadyout_o = !s_q.rd_wait;
    assign hresp_o = 1'b0;

    assign ana_o.sample = sar_busy;
    assign ana_o.chan = s_q.ch;
    assign ana_o.code = sar_code;

    // Each mask bit enables its own event, end or channel, onto the conversion-end interrupt
    assign conversion_end_interrupt_o = |(s_q.status & s_q.mask);
endmodule : acs_seq

/* acs_ana_model.sv */
// Behavioural comparator core facing the sequencer's analogue drive
`timescale 1ns/1ps
module acs_ana_model (
    // Clock
    input wire logic clk_i,
    // Drive from the sequencer, analogue levels, answer speed
    input wire acs_pkg::acs_ana_s ana_i,
    input wire logic [3:0][9:0] level_i,
    input wire logic slow_i,
    // Decision
    output logic cmp_o
);
    logic now_w;
    logic late_q = 1'b0;
    logic last_q = 1'b0;
    assign now_w = level_i[ana_i.chan] >= ana_i.code;
    always @(posedge clk_i) begin
        late_q <= now_w;
        last_q <= cmp_o;
    end
    // Toggles outside sampling so a stale decision never looks valid
    assign cmp_o = !ana_i.sample ? !last_q : (slow_i ? late_q : now_w);
endmodule : acs_ana_model

/* acs_seq_sva.sv */
// Port-level checks on the conversion sequencer
`timescale 1ns/1ps
module acs_seq_sva (
    // Watched ports
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire acs_pkg::acs_ana_s ana_o,
    input wire logic conversion_end_interrupt_o
);
    localparam int STALL_MAX = 24;
    logic [7:0] still_q;
    logic wr_w;
    logic rd_w;
    assign wr_w = hsel_i & htrans_i[1] & hready_i & hwrite_i;
    assign rd_w = hsel_i & htrans_i[1] & hready_i & !hwrite_i;
    // Cycles the trial code has stood during sampling
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            still_q <= 8'h00;
        end else if (!ana_o.sample || $changed(ana_o.code)) begin
            still_q <= 8'h00;
        end else if (still_q != 8'hFF) begin
            still_q <= still_q + 8'h01;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    sequence s_one_wait;
        !hreadyout_o ##1 hreadyout_o;
    endsequence
    sequence s_read_go;
        rd_w;
    endsequence
    chk_resp_okay: assert property (hresp_o == 1'b0)
        else $error("error response seen");
    chk_read_wait: assert property (s_read_go |=> s_one_wait)
        else $error("read wait state wrong");
    chk_write_fast: assert property (wr_w |=> hreadyout_o)
        else $error("write stalled");
    chk_stall_cause: assert property ($fell(hreadyout_o) |-> $past(rd_w))
        else $error("stall without read");
    chk_rdata_hold: assert property ($changed(hrdata_o) |-> hreadyout_o && !$past(hreadyout_o))
        else $error("read data moved outside a read");
    chk_reset_quiet: assert property ($fell(reset_i) |->
        !conversion_end_interrupt_o && !ana_o.sample && hreadyout_o && hrdata_o == 32'h0000_0000)
        else $error("outputs not idle after reset");
    chk_irq_cause: assert property ($rose(conversion_end_interrupt_o) |->
        $past(wr_w, 2) || $past(wr_w, 3) || $past(ana_o.sample) || $past(ana_o.sample, 2)
        || $past(ana_o.sample, 3)) else $error("interrupt without cause");
    chk_code_moves: assert property (still_q <= STALL_MAX)
        else $error("trial code stuck");
endmodule : acs_seq_sva

bind acs_seq acs_seq_sva acs_seq_sva_i (
    .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .ana_o(ana_o),
    .conversion_end_interrupt_o(conversion_end_interrupt_o)
);

/* acs_seq_bench.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module acs_seq_bench;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic trig = 1'b0;
    logic slow = 1'b0;
    logic [3:0][9:0] lvl = '0;
    logic [31:0] seed = 32'h0000_0051;
    logic rd_pend = 1'b0;
    logic cmp;
    logic hready;
    logic irq;
    logic [31:0] hrdata;
    acs_pkg::acs_ana_s ana;
    logic [31:0] exp_q[$];
    string name_q[$];
    int n_errors = 0;
    int num_checks = 0;

    always #4 clk_i = ~clk_i;

    acs_seq acs_seq_i (
        .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(acs_pkg::HSIZE_WORD),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(), .ext_trigger_i(trig), .comparator_i(cmp), .ana_o(ana),
        .conversion_end_interrupt_o(irq)
    );
    acs_ana_model acs_ana_model_i (
        .clk_i(clk_i), .ana_i(ana), .level_i(lvl), .slow_i(slow), .cmp_o(cmp)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    task automatic chk_word(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit

    // Read data is taken at the edge that ends the data phase
    always @(posedge clk_i) begin
        if (rd_pend && hready) begin
            chk_word(name_q.pop_front(), exp_q.pop_front(), hrdata);
            rd_pend <= 1'b0;
        end
        if (hsel && htrans[1] && hready && !hwrite) begin
            rd_pend <= 1'b1;
        end
    end

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_i); while (hready !== 1'b1);
    endtask : bus

    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        name_q.push_back(what);
        bus(1'b0, a, 32'h0000_0000);
    endtask : rd

    task automatic clr;
        bus(1'b1, acs_pkg::OFS_STATUS, 32'h0000_0003);
        repeat (3) @(posedge clk_i);
    endtask : clr

    task automatic wait_irq(input int lim);
        for (int k = 0; k < lim && irq !== 1'b1; k++) @(posedge clk_i);
    endtask : wait_irq

    task automatic pulse;
        trig <= 1'b1;
        repeat (6) @(posedge clk_i);
        trig <= 1'b0;
    endtask : pulse

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : wrap_up

    initial begin : watchdog
        #80000;
        n_errors++;
        wrap_up();
    end

    initial begin
        logic m;
        repeat (8) @(posedge clk_i);
        reset_i <= 1'b0;
        rd("ctrl", acs_pkg::OFS_CTRL, 32'h0000_0000);
        rd("status", acs_pkg::OFS_STATUS, 32'h0000_0000);
        rd("mask", acs_pkg::OFS_MASK, 32'h0000_0000);
        rd("unmapped", 8'h40, 32'h0000_0000);
        chk_bit("irq", 1'b0, irq);
        $display("test reset done");
        for (int ch = 0; ch < 4; ch++) begin
            seed = xs(seed);
            m = seed[11];
            lvl[ch] <= seed[9:0];
            slow <= seed[10];
            bus(1'b1, acs_pkg::OFS_MASK, {31'h0000_0000, m});
            bus(1'b1, acs_pkg::OFS_CTRL, 32'h0000_0001 | (32'(ch) << 2));
            if (m) begin
                wait_irq(200);
            end else begin
                repeat (120) @(posedge clk_i);
            end
            chk_bit("irq", m, irq);
            rd("data", acs_pkg::OFS_DATA0 + 8'(4 * ch), 32'(lvl[ch]));
            rd("status", acs_pkg::OFS_STATUS, 32'h0000_0003);
            rd("ctrl", acs_pkg::OFS_CTRL, 32'(ch) << 2);
            clr();
            chk_bit("irq", 1'b0, irq);
        end
        $display("test single done");
        bus(1'b1, acs_pkg::OFS_MASK, 32'h0000_0001);
        bus(1'b1, acs_pkg::OFS_CTRL, 32'h0000_000B);
        repeat (200) @(posedge clk_i);
        chk_bit("irq", 1'b0, irq);
        wait_irq(200);
        chk_bit("irq", 1'b1, irq);
        rd("data1", acs_pkg::OFS_DATA1, 32'(lvl[1]));
        rd("data2", acs_pkg::OFS_DATA2, 32'(lvl[2]));
        rd("ctrl", acs_pkg::OFS_CTRL, 32'h0000_000B);
        seed = xs(seed);
        lvl[2] <= seed[9:0];
        clr();
        wait_irq(400);
        chk_bit("irq", 1'b1, irq);
        rd("data2", acs_pkg::OFS_DATA2, 32'(lvl[2]));
        // Start, scan and channel cleared together before the mode changes below
        bus(1'b1, acs_pkg::OFS_CTRL, 32'h0000_0000);
        clr();
        repeat (400) @(posedge clk_i);
        rd("status", acs_pkg::OFS_STATUS, 32'h0000_0000);
        $display("test scan done");
        seed = xs(seed);
        lvl[1] <= seed[9:0];
        bus(1'b1, acs_pkg::OFS_CTRL, 32'h0000_0014);
        pulse();
        wait_irq(200);
        chk_bit("irq", 1'b1, irq);
        rd("data1", acs_pkg::OFS_DATA1, 32'(lvl[1]));
        rd("ctrl", acs_pkg::OFS_CTRL, 32'h0000_0014);
        clr();
        bus(1'b1, acs_pkg::OFS_CTRL, 32'h0000_0004);
        pulse();
        repeat (120) @(posedge clk_i);
        rd("status", acs_pkg::OFS_STATUS, 32'h0000_0000);
        $display("test trigger done");
        wrap_up();
    end
endmodule : acs_seq_bench
